// >>> inc/ppg_defines.svh
// Register map, field codes and divider masks of the pulse generator
`ifndef PPG_DEFINES_SVH
`define PPG_DEFINES_SVH

`define ADDR_CTRL    8'h00
`define ADDR_PERIOD  8'h04
`define ADDR_TOGGLE  8'h08
`define ADDR_COUNT   8'h0c
`define ADDR_STATUS  8'h10
`define ADDR_MASK    8'h14

`define CTRL_RESET   8'h00
`define CTRL_W       8
`define WORD_RESET   16'h0000
`define IRQ_W        2
`define EVT_TOGGLE   0
`define EVT_PERIOD   1

`define FS_TIMER     2'h0
`define FS_PULSE     2'h3

`define SS_STOP      2'h0
`define SS_CMD       2'h1
`define SS_RISE      2'h2
`define SS_FALL      2'h3

`define PS_W         10
`define PS_MASK0     10'h000
`define PS_MASK1     10'h007
`define PS_MASK2     10'h07f
`define PS_MASK3     10'h3ff

`endif

// >>> inc/ppg_pkg.sv
// Types shared by the pulse generator files
package ppg_pkg;

   typedef struct packed
   {
      logic        output_flop_preset;
      logic        repeat_select;
      logic [1:0]  start_source_select;
      logic [1:0]  clock_select;
      logic [1:0]  function_select;
   } ctrl_s;

   typedef struct packed
   {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } bus_req_s;

   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'h1,
      ST_ARMED = 3'h2,
      ST_RUN   = 3'h4
   } state_e;

endpackage

// >>> rtl/ppg_sync.sv
// Two-stage synchroniser for the trigger pin
`timescale 1ns/1ps
module ppg_sync
(
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic d,
   output logic      q
);
   logic meta;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta <= 1'b0;
         q    <= 1'b0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// >>> rtl/ppg_prescaler.sv
// Source clock divider giving a one-cycle count enable
`timescale 1ns/1ps
`include "ppg_defines.svh"
module ppg_prescaler
(
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic [1:0] sel,
   output logic            tick
);
   logic [`PS_W-1:0] cnt;
   logic [`PS_W-1:0] m;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         cnt <= '0;
      else
         cnt <= cnt + 1'b1;
   end

   // Free running, so a rate change takes effect mid period
   always_comb
   begin
      case (sel)
         2'h0:    m = `PS_MASK0;
         2'h1:    m = `PS_MASK1;
         2'h2:    m = `PS_MASK2;
         default: m = `PS_MASK3;
      endcase
      tick = ((cnt & m) == m);
   end
endmodule

// >>> rtl/programmable_pulse_generator.sv
// Programmable pulse generator of a 16-bit timer with register port
//
// Operation
// - The counter advances only on the internal source tick, never on pin edges.
// - The start field picks a command start or a chosen edge of the trigger pin.
// - Repeat select 0 gives continuous pulses, 1 a single one-shot pulse.
// - A toggle match inverts the output, raises an event, and counting goes on.
// - In continuous mode a period match inverts, raises an event, clears the count.
// - Writing the stop code while running leaves the output at its last level.
// - In one-shot mode a period match writes the stop code and halts the timer.
// - The output pin is the inverse of the output flip-flop.
// - Reset clears the output flip-flop to zero.
// - Going from timer mode to pulse mode loads the flip-flop from the preset bit.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "ppg_defines.svh"
module programmable_pulse_generator
(
   input  wire logic               mclk,
   input  wire logic               resetn,
   input  wire ppg_pkg::bus_req_s  bus_req,
   output logic [15:0]             rdata,
   input  wire logic               trigger_input_pin,
   output logic                    pulse_output_pin,
   output logic                    timer_one_irq
);
   ppg_pkg::ctrl_s   ctrl;
   ppg_pkg::ctrl_s   next_ctrl;
   ppg_pkg::ctrl_s   wctrl;
   ppg_pkg::state_e  state;
   ppg_pkg::state_e  next_state;
   logic [15:0]      period;
   logic [15:0]      next_period;
   logic [15:0]      toggle;
   logic [15:0]      next_toggle;
   logic [15:0]      count;
   logic [15:0]      next_count;
   logic             out_flop;
   logic             next_out_flop;
   logic [`IRQ_W-1:0] status;
   logic [`IRQ_W-1:0] next_status;
   logic [`IRQ_W-1:0] mask;
   logic [`IRQ_W-1:0] next_mask;
   logic [`IRQ_W-1:0] match_evt;
   logic             next_irq;
   logic [15:0]      next_rdata;
   logic             tick;
   logic             trig_s;
   logic             trig_d;
   logic             trig_edge;
   logic             wr_ctrl;
   logic             load;
   logic             pulse_mode;
   logic             stop_req;

   ppg_sync u_sync
   (
      .mclk   (mclk),
      .resetn (resetn),
      .d      (trigger_input_pin),
      .q      (trig_s)
   );

   ppg_prescaler u_prescaler
   (
      .mclk   (mclk),
      .resetn (resetn),
      .sel    (ctrl.clock_select),
      .tick   (tick)
   );

   assign wctrl      = ppg_pkg::ctrl_s'(bus_req.wdata[`CTRL_W-1:0]);
   assign wr_ctrl    = bus_req.wr && (bus_req.addr == `ADDR_CTRL);
   assign pulse_mode = (ctrl.function_select == `FS_PULSE);
   assign stop_req   = !pulse_mode ||
                       (ctrl.start_source_select == `SS_STOP);
   // Only the timer-to-pulse step loads, so a restart keeps the level
   assign load = wr_ctrl && !pulse_mode &&
                 (wctrl.function_select == `FS_PULSE);

   always_comb
   begin
      case (ctrl.start_source_select)
         `SS_RISE: trig_edge = trig_s && !trig_d;
         `SS_FALL: trig_edge = !trig_s && trig_d;
         default:  trig_edge = 1'b0;
      endcase
   end

   // Timer control group
   always_comb
   begin
      next_ctrl     = ctrl;
      next_period   = period;
      next_toggle   = toggle;
      next_state    = state;
      next_count    = count;
      next_out_flop = out_flop;
      match_evt     = '0;
      if (wr_ctrl)
         next_ctrl = wctrl;
      if (bus_req.wr && bus_req.addr == `ADDR_PERIOD)
         next_period = bus_req.wdata;
      if (bus_req.wr && bus_req.addr == `ADDR_TOGGLE)
         next_toggle = bus_req.wdata;
      if (load)
         next_out_flop = wctrl.output_flop_preset;
      if (stop_req)
      begin
         // Output is left untouched on stop
         next_state = ppg_pkg::ST_IDLE;
         next_count = `WORD_RESET;
      end
      else
      begin
         case (state)
            ppg_pkg::ST_IDLE:
            begin
               if (ctrl.start_source_select == `SS_CMD)
                  next_state = ppg_pkg::ST_RUN;
               else
                  next_state = ppg_pkg::ST_ARMED;
            end
            ppg_pkg::ST_ARMED:
            begin
               if (trig_edge)
                  next_state = ppg_pkg::ST_RUN;
            end
            ppg_pkg::ST_RUN:
            begin
               if (tick)
               begin
                  if (count == period)
                  begin
                     next_out_flop = !out_flop;
                     match_evt[`EVT_PERIOD] = 1'b1;
                     next_count = `WORD_RESET;
                     if (ctrl.repeat_select)
                     begin
                        // Hardware stop beats a same-cycle control write
                        next_ctrl.start_source_select = `SS_STOP;
                        next_state = ppg_pkg::ST_IDLE;
                     end
                  end
                  else if (count == toggle)
                  begin
                     next_out_flop = !out_flop;
                     match_evt[`EVT_TOGGLE] = 1'b1;
                     next_count = count + 1'b1;
                  end
                  else
                     next_count = count + 1'b1;
               end
            end
            default:
               next_state = ppg_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl             <= ppg_pkg::ctrl_s'(`CTRL_RESET);
         period           <= `WORD_RESET;
         toggle           <= `WORD_RESET;
         count            <= `WORD_RESET;
         state            <= ppg_pkg::ST_IDLE;
         out_flop         <= 1'b0;
         pulse_output_pin <= 1'b1;
         trig_d           <= 1'b0;
      end
      else
      begin
         ctrl             <= next_ctrl;
         period           <= next_period;
         toggle           <= next_toggle;
         count            <= next_count;
         state            <= next_state;
         out_flop         <= next_out_flop;
         pulse_output_pin <= !next_out_flop;
         trig_d           <= trig_s;
      end
   end

   // Interrupt and read-back group
   always_comb
   begin
      next_status = status;
      next_mask   = mask;
      next_rdata  = `WORD_RESET;
      if (bus_req.wr && bus_req.addr == `ADDR_STATUS)
         next_status = status & ~bus_req.wdata[`IRQ_W-1:0];
      // A match in the clearing cycle is kept
      next_status = next_status | match_evt;
      if (bus_req.wr && bus_req.addr == `ADDR_MASK)
         next_mask = bus_req.wdata[`IRQ_W-1:0];
      next_irq = |(next_status & next_mask);
      if (bus_req.rd)
      begin
         case (bus_req.addr)
            `ADDR_CTRL:   next_rdata = {8'h00, ctrl};
            `ADDR_PERIOD: next_rdata = period;
            `ADDR_TOGGLE: next_rdata = toggle;
            `ADDR_COUNT:  next_rdata = count;
            `ADDR_STATUS: next_rdata = {14'h0000, status};
            `ADDR_MASK:   next_rdata = {14'h0000, mask};
            default:      next_rdata = `WORD_RESET;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         status        <= '0;
         mask          <= '0;
         timer_one_irq <= 1'b0;
         rdata         <= `WORD_RESET;
      end
      else
      begin
         status        <= next_status;
         mask          <= next_mask;
         timer_one_irq <= next_irq;
         rdata         <= next_rdata;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   chk_pin_inverse: assert property (
      pulse_output_pin == !out_flop)
      else $error("pulse pin is not the inverse of the flop");

   chk_reset_flop: assert property (
      @(posedge mclk) disable iff (1'b0)
      $rose(resetn) |-> (!out_flop && pulse_output_pin))
      else $error("flop not cleared by reset");

   chk_toggle_match: assert property (
      (state == ppg_pkg::ST_RUN) && tick && !stop_req &&
      (count == toggle) && (count != period)
      |=> (out_flop != $past(out_flop)) &&
          (count == $past(count) + 16'h0001) && status[`EVT_TOGGLE])
      else $error("toggle match mishandled");

   chk_period_clear: assert property (
      (state == ppg_pkg::ST_RUN) && tick && !stop_req &&
      (count == period) && !ctrl.repeat_select && !wr_ctrl
      |=> (count == 16'h0000) && (state == ppg_pkg::ST_RUN) &&
          (out_flop != $past(out_flop)) && status[`EVT_PERIOD])
      else $error("period match did not clear and continue");

   chk_oneshot_stop: assert property (
      (state == ppg_pkg::ST_RUN) && tick && !stop_req &&
      (count == period) && ctrl.repeat_select
      |=> (ctrl.start_source_select == `SS_STOP) &&
          (state == ppg_pkg::ST_IDLE) ##1 $stable(pulse_output_pin))
      else $error("one-shot did not halt");

   chk_stop_hold: assert property (
      stop_req && !load |=> $stable(out_flop))
      else $error("output moved while stopped");

   chk_count_tick: assert property (
      (state == ppg_pkg::ST_RUN) && !tick && !stop_req
      |=> $stable(count))
      else $error("count moved without a source tick");

   chk_trigger_start: assert property (
      (state == ppg_pkg::ST_ARMED) && !stop_req && trig_edge
      |=> (state == ppg_pkg::ST_RUN) && (count == 16'h0000))
      else $error("trigger edge did not start the timer");

   chk_event_single: assert property (
      match_evt != '0 |=> (status & $past(match_evt)) == $past(match_evt))
      else $error("match event was lost");

   chk_load_preset: assert property (
      load |=> (out_flop == $past(wctrl.output_flop_preset)) &&
               (pulse_output_pin == !out_flop))
      else $error("preset not loaded on mode change");

   // Each event bit is a single-cycle strobe into the sticky status, save the period bit in continuous mode at period 0 with clock select 0
   chk_event_once: assert property (
      match_evt != '0 |=> (match_evt & $past(match_evt)) == '0)
      else $error("match event lasted more than one cycle");

   chk_irq_level: assert property (
      timer_one_irq == |(status & mask))
      else $error("interrupt level does not follow status and mask");

   chk_repeat_run: assert property (
      (state == ppg_pkg::ST_RUN) && tick && !stop_req &&
      (count == period) && !ctrl.repeat_select && !wr_ctrl
      |=> ctrl.start_source_select == $past(ctrl.start_source_select))
      else $error("continuous mode stopped on period match");

   chk_idle_clear: assert property (
      state == ppg_pkg::ST_IDLE |-> count == 16'h0000)
      else $error("stopped counter not cleared");

   chk_armed_wait: assert property (
      (state == ppg_pkg::ST_ARMED) && !stop_req && !trig_edge
      |=> (state == ppg_pkg::ST_ARMED) && (count == 16'h0000))
      else $error("timer left the armed state without a trigger");
endmodule

// >>> dv/pulse_load_model.sv
// Load on the pulse pin, measuring its high and low widths in clock cycles
`timescale 1ns/1ps
module pulse_load_model
(
   input  wire logic   mclk,
   input  wire logic   resetn,
   input  wire logic   pulse_output_pin,
   output logic [15:0] high_width,
   output logic [15:0] low_width,
   output logic [15:0] edge_count
);
   logic        last_level;
   logic [15:0] run;

   // Whole cycles only, so a level seen at one edge reads as 1 and a glitch between edges is missed
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         last_level <= 1'b1;
         run        <= 16'h0000;
         high_width <= 16'h0000;
         low_width  <= 16'h0000;
         edge_count <= 16'h0000;
      end
      else if (pulse_output_pin !== last_level)
      begin
         if (last_level)
            high_width <= run;
         else
            low_width <= run;
         run        <= 16'h0001;
         edge_count <= edge_count + 16'h0001;
         last_level <= pulse_output_pin;
      end
      else
         run <= run + 16'h0001;
   end
endmodule

// >>> dv/programmable_pulse_generator_bench.sv
// Register-level bench of the pulse generator
`timescale 1ns/1ps
`include "ppg_defines.svh"
`define CHECK(nm, e, s) begin checked++; if ((s) !== (e)) begin \
   n_mismatch++; $display("Error %s expected %h seen %h", nm, e, s); end end
module programmable_pulse_generator_bench;
   logic              mclk;
   logic              resetn;
   ppg_pkg::bus_req_s bus_req;
   logic [15:0]       rdata;
   logic              trigger_input_pin;
   logic              pulse_output_pin;
   logic              timer_one_irq;
   logic [15:0]       high_width;
   logic [15:0]       low_width;
   logic [15:0]       edge_count;
   logic [15:0]       edges_seen;
   logic              held_level;
   int                n_mismatch = 0;
   int                checked = 0;
   int                cycles = 0;

   programmable_pulse_generator programmable_pulse_generator_inst
   (
      .mclk              (mclk),
      .resetn            (resetn),
      .bus_req           (bus_req),
      .rdata             (rdata),
      .trigger_input_pin (trigger_input_pin),
      .pulse_output_pin  (pulse_output_pin),
      .timer_one_irq     (timer_one_irq)
   );

   pulse_load_model pulse_load_model_inst
   (
      .mclk             (mclk),
      .resetn           (resetn),
      .pulse_output_pin (pulse_output_pin),
      .high_width       (high_width),
      .low_width        (low_width),
      .edge_count       (edge_count)
   );

   task automatic complete_run();
      if (n_mismatch == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      bus_req <= '0;
   endtask

   // Read data stands one cycle only, so it is sampled just after it lands
   task automatic rd(input logic [7:0] a, input logic [15:0] e,
                     input string nm);
      @(posedge mclk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge mclk);
      bus_req <= '0;
      #1;
      `CHECK(nm, e, rdata)
   endtask

   task automatic wait_pin(input logic lvl, input int lim);
      int n;
      n = 0;
      while (pulse_output_pin !== lvl && n < lim)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      `CHECK("pin", lvl, pulse_output_pin)
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // Timer mode first, so the pulse mode entry reloads the output flop
   task automatic init(input logic pre);
      wr(`ADDR_CTRL, 16'h0000);
      wr(`ADDR_CTRL, {8'h00, pre, 7'h03});
   endtask

   initial
   begin
      mclk = 1'b0;
   end
   always #2.5 mclk = ~mclk;

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         complete_run();
      end
   end

   initial
   begin
      resetn = 1'b0;
      bus_req = '0;
      trigger_input_pin = 1'b0;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      #1;
      `CHECK("pin", 1'b1, pulse_output_pin)
      `CHECK("irq", 1'b0, timer_one_irq)
      rd(`ADDR_CTRL, 16'h0000, "ctrl");
      rd(8'h1c, 16'h0000, "unmapped");
      wr(`ADDR_COUNT, 16'h1234);
      rd(`ADDR_COUNT, 16'h0000, "count");
      // One-shot, command start
      init(1'b0);
      wr(`ADDR_TOGGLE, 16'h0003);
      wr(`ADDR_PERIOD, 16'h0006);
      wr(`ADDR_MASK, 16'h0000);
      wr(`ADDR_CTRL, 16'h0053);
      wait_pin(1'b0, 50);
      wait_pin(1'b1, 50);
      idle(3);
      `CHECK("low width", 16'h0003, low_width)
      edges_seen = edge_count;
      rd(`ADDR_CTRL, 16'h0043, "ctrl");
      idle(20);
      `CHECK("edges", edges_seen, edge_count)
      `CHECK("pin", 1'b1, pulse_output_pin)
      rd(`ADDR_STATUS, 16'h0003, "status");
      `CHECK("irq", 1'b0, timer_one_irq)
      wr(`ADDR_MASK, 16'h0003);
      idle(2);
      `CHECK("irq", 1'b1, timer_one_irq)
      wr(`ADDR_STATUS, 16'h0001);
      rd(`ADDR_STATUS, 16'h0002, "status");
      `CHECK("irq", 1'b1, timer_one_irq)
      wr(`ADDR_MASK, 16'h0001);
      idle(2);
      `CHECK("irq", 1'b0, timer_one_irq)
      wr(`ADDR_STATUS, 16'h0002);
      rd(`ADDR_STATUS, 16'h0000, "status");
      // Continuous, inverted start level
      init(1'b1);
      idle(2);
      `CHECK("pin", 1'b0, pulse_output_pin)
      wr(`ADDR_TOGGLE, 16'h0002);
      wr(`ADDR_PERIOD, 16'h0007);
      wr(`ADDR_CTRL, 16'h0093);
      wait_pin(1'b1, 50);
      wait_pin(1'b0, 50);
      wait_pin(1'b1, 50);
      idle(2);
      `CHECK("high width", 16'h0005, high_width)
      `CHECK("low width", 16'h0003, low_width)
      // Stop code written while the timer runs, preset bit unchanged
      wr(`ADDR_CTRL, 16'h0083);
      idle(3);
      held_level = pulse_output_pin;
      edges_seen = edge_count;
      idle(30);
      `CHECK("pin", held_level, pulse_output_pin)
      `CHECK("edges", edges_seen, edge_count)
      rd(`ADDR_COUNT, 16'h0000, "count");
      // Rising trigger, compare values beyond the low byte
      init(1'b0);
      wr(`ADDR_TOGGLE, 16'h0100);
      wr(`ADDR_PERIOD, 16'h0104);
      wr(`ADDR_CTRL, 16'h0063);
      idle(40);
      `CHECK("pin", 1'b1, pulse_output_pin)
      rd(`ADDR_COUNT, 16'h0000, "count");
      @(posedge mclk);
      trigger_input_pin <= 1'b1;
      idle(20);
      // Period moved while running, far above the present count
      wr(`ADDR_PERIOD, 16'h0108);
      wait_pin(1'b0, 400);
      wait_pin(1'b1, 20);
      idle(3);
      `CHECK("low width", 16'h0008, low_width)
      // Falling trigger, source tick every eighth cycle
      init(1'b0);
      wr(`ADDR_TOGGLE, 16'h0001);
      wr(`ADDR_PERIOD, 16'h0002);
      wr(`ADDR_CTRL, 16'h0077);
      idle(20);
      `CHECK("pin", 1'b1, pulse_output_pin)
      @(posedge mclk);
      trigger_input_pin <= 1'b0;
      wait_pin(1'b0, 40);
      wait_pin(1'b1, 20);
      idle(3);
      `CHECK("low width", 16'h0008, low_width)
      complete_run();
   end
endmodule
